// *** hw/sld_driver.sv ***
// Segment display driver: register slave, clock gating, frame timing, pin drive
//
// How it works
// RULE1: frame = clock / (16 x (frame+1) x (duty+1))
// RULE2: frame divider field is four bits, 0..15
// RULE3: duty field three bits; value+1 commons driven
// RULE4: debug without run bit stops operating clock
// RULE5: suspended: stop, blank display, keep registers
// RULE6: debug run bit keeps clock through debug
// RULE7: software picks clock source and divider
// RULE8: software keeps source oscillator running in sleep
// RULE9: off pins drive ground if discharge, else float
// RULE10: software sets discharge when panel attached
// RULE11: frame monitor pin idles low; here only reset clears it, a stopped or suspended display holds its level
// RULE12: four shared pins: commons 4-7 or segments 0-3
// RULE13: 56 segments to 4 commons, 52 beyond
// RULE14: 112-byte display data memory
// RULE15: two drive waveform types, A and B
// RULE16: all on, all off, inverted display modes
// RULE17: segment and common order reversible
// RULE18: partial drive masks commons
// RULE19: polarity inversion every n lines
// RULE20: 32-step contrast, internal generation only
// RULE21: interrupt cause once per frame
// RULE22: display control codes off/normal/all-on/all-off
// RULE23: flag write-one-clear, enable gates interrupt
// RULE24: frame monitor toggles each frame
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module sld_driver
  import sld_pkg::*;
#(
  parameter int SRC_NUM = 4
) (
  // Clock and reset
  input  wire  logic                    i_mclk,
  input  wire  logic                    i_nrst,
  // AHB-Lite slave
  input  wire  logic                    i_hsel,
  input  wire  logic [31:0]             i_haddr,
  input  wire  logic [1:0]              i_htrans,
  input  wire  logic                    i_hwrite,
  input  wire  logic [2:0]              i_hsize,
  input  wire  logic [31:0]             i_hwdata,
  input  wire  logic                    i_hready,
  output logic                          o_hreadyout,
  output logic [31:0]                   o_hrdata,
  output logic                          o_hresp,
  // Clock generator and CPU state
  input  wire  logic [SRC_NUM-1:0]      i_src_tick,
  input  wire  logic                    i_cpu_debug,
  // Panel side
  output logic [3:0]                    o_com,
  output logic [3:0]                    o_shared,
  output logic [SLD_NSEG-5:0]           o_seg,
  output logic                          o_pin_oe,
  output logic                          o_polarity,
  output logic                          o_wave_b,
  output logic [4:0]                    o_contrast,
  output logic                          o_internal_gen,
  output logic                          o_frame_monitor,
  output logic                          o_frame_irq
);

  if (SRC_NUM < 1 || SRC_NUM > 4) begin : g_chk
    $error("SRC_NUM must be 1 to 4");
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a[11:2] == ofs[11:2];
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes take no wait, reads one wait state
  sld_cfg_s    cfg;
  logic [11:0] a_addr;
  logic        wr_pend;
  logic        rd_pend;
  logic        flag;
  logic [7:0]  ram [0:SLD_RAM_BYTES-1];

  wire acc     = i_hsel && i_htrans[1] && i_hready;
  wire wr_ctrl = wr_pend && hit(a_addr, SLD_OFS_CTRL);
  wire wr_clk  = wr_pend && hit(a_addr, SLD_OFS_CLK);
  wire wr_tim1 = wr_pend && hit(a_addr, SLD_OFS_TIM1);
  wire wr_tim2 = wr_pend && hit(a_addr, SLD_OFS_TIM2);
  wire wr_pwr  = wr_pend && hit(a_addr, SLD_OFS_PWR);
  wire wr_dsp  = wr_pend && hit(a_addr, SLD_OFS_DSP);
  wire wr_intf = wr_pend && hit(a_addr, SLD_OFS_INTF);
  wire wr_inte = wr_pend && hit(a_addr, SLD_OFS_INTE);
  wire ram_hit = (a_addr[11:8] == SLD_RAM_PAGE) && (a_addr[7:2] < SLD_RAM_WORDS);
  wire [6:0] ram_base = {a_addr[6:2], 2'b00};

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      a_addr      <= 12'h000;
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      o_hreadyout <= 1'b1;
    end else begin
      if (acc) begin
        a_addr <= i_haddr[11:0];
      end
      wr_pend     <= acc && i_hwrite;
      rd_pend     <= acc && !i_hwrite;
      o_hreadyout <= !(acc && !i_hwrite);
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg <= SLD_CFG_RST;
    end else begin
      if (wr_ctrl) begin
        cfg.moden     <= i_hwdata[SLD_CTRL_EN];
        cfg.discharge <= i_hwdata[SLD_CTRL_DIS];
      end
      if (wr_clk) begin // see RULE7
        cfg.src   <= i_hwdata[SLD_CLK_SRC +: 2];
        cfg.div   <= i_hwdata[SLD_CLK_DIV +: 3];
        cfg.debug_run_enable <= i_hwdata[SLD_CLK_DEBUG_RUN_ENABLE];
      end
      if (wr_tim1) begin // see RULE2
        cfg.duty <= i_hwdata[SLD_TIM1_DUTY +: 3];
        cfg.frm  <= i_hwdata[SLD_TIM1_FRM +: 4];
      end
      if (wr_tim2) begin
        cfg.wave_b <= i_hwdata[SLD_TIM2_WAVEB];
        cfg.nline  <= i_hwdata[SLD_TIM2_NLINE +: 3];
      end
      if (wr_pwr) begin
        cfg.lc     <= i_hwdata[SLD_PWR_LC +: 5];
        cfg.intgen <= i_hwdata[SLD_PWR_INTGEN];
      end
      if (wr_dsp) begin
        cfg.display_state_control   <= i_hwdata[SLD_DSP_DISPLAY_STATE_CONTROL +: 2];
        cfg.inv    <= i_hwdata[SLD_DSP_INV];
        cfg.area   <= i_hwdata[SLD_DSP_AREA];
        cfg.comrev <= i_hwdata[SLD_DSP_COMREV];
        cfg.segrev <= i_hwdata[SLD_DSP_SEGREV];
        cfg.part   <= i_hwdata[SLD_DSP_PART +: 8];
      end
      if (wr_inte) begin
        cfg.ie <= i_hwdata[0];
      end
    end
  end

  // Display memory has no reset; software fills it before display on
  // One process writes all four byte lanes, so the array has a single driver
  always_ff @(posedge i_mclk) begin
    if (wr_pend && ram_hit) begin // see RULE14
      for (int b = 0; b < 4; b++) begin
        ram[ram_base + 7'(b)] <= i_hwdata[8*b +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operating clock: source select, divider, debug suspension
  logic [6:0] div_cnt;
  wire  susp     = i_cpu_debug && !cfg.debug_run_enable; // see RULE4
  wire  clk_run  = cfg.moden && !susp; // see RULE6
  wire  src_tick = (32'(cfg.src) < SRC_NUM) ? i_src_tick[cfg.src] : 1'b0;
  wire  [6:0] div_mask = 7'((8'h01 << cfg.div) - 8'h01);
  wire  op_tick  = clk_run && src_tick && ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt <= 7'h00;
    end else if (clk_run && src_tick) begin
      div_cnt <= div_cnt + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame timing: 16 x (frame+1) ticks per common line, duty+1 lines
  logic [7:0] sub_cnt;
  logic [2:0] line;
  logic [2:0] nline_cnt;
  wire  [7:0] sub_max   = {cfg.frm, 4'hf}; // see RULE1
  wire        line_end  = op_tick && (sub_cnt >= sub_max);
  wire        frame_end = line_end && (line >= cfg.duty); // see RULE3
  wire        nline_hit = line_end && (cfg.nline != 3'h0) && (nline_cnt >= cfg.nline - 3'h1);
  wire        tog_pol   = (line_end && !cfg.wave_b) ^ (frame_end && cfg.wave_b) ^ nline_hit;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sub_cnt   <= 8'h00;
      line      <= 3'h0;
      nline_cnt <= 3'h0;
    end else if (!cfg.moden) begin
      sub_cnt   <= 8'h00;
      line      <= 3'h0;
      nline_cnt <= 3'h0;
    end else if (op_tick) begin // suspension freezes all timing state, see RULE5
      sub_cnt <= line_end ? 8'h00 : sub_cnt + 8'h01;
      if (line_end) begin
        line      <= frame_end ? 3'h0 : line + 3'h1;
        nline_cnt <= nline_hit ? 3'h0 : nline_cnt + 3'h1; // see RULE19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive pattern
  wire [6:0] row_base = 7'({4'h0, line} * 7'd14) + (cfg.area ? 7'd7 : 7'd0);
  wire [2:0] com_pin  = cfg.comrev ? cfg.duty - line : line; // see RULE17
  wire [7:0] duty_msk = 8'((9'h002 << cfg.duty) - 9'h001);
  wire [7:0] com_on   = (8'h01 << com_pin) & duty_msk & cfg.part; // see RULE18
  wire [7:0] com_stat = duty_msk & cfg.part;
  wire       blank    = susp || !cfg.moden || (cfg.display_state_control == SLD_DSP_OFF);
  wire [SLD_NSEG-1:0] seg_raw;
  wire [SLD_NSEG-1:0] seg_ord;

  for (genvar k = 0; k < SLD_NSEG / 8; k++) begin : g_row
    assign seg_raw[8*k +: 8] = ram[row_base + 7'(k)];
  end
  for (genvar s = 0; s < SLD_NSEG; s++) begin : g_rev
    assign seg_ord[s] = cfg.segrev ? seg_raw[SLD_NSEG-1-s] : seg_raw[s];
  end

  // see RULE16 RULE22
  wire [SLD_NSEG-1:0] seg_vec =
    (cfg.display_state_control == SLD_DSP_ALLON)  ? {SLD_NSEG{1'b1}} :
    (cfg.display_state_control == SLD_DSP_ALLOFF) ? {SLD_NSEG{1'b0}} :
    seg_ord ^ {SLD_NSEG{cfg.inv}};
  wire [7:0] com_vec = (cfg.display_state_control == SLD_DSP_ALLOFF) ? com_stat : com_on;
  wire       shared_com = cfg.duty >= SLD_DUTY_SHARED; // see RULE12 RULE13

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_com    <= 4'h0;
      o_shared <= 4'h0;
      o_seg    <= '0;
      o_pin_oe <= 1'b0;
    end else if (blank) begin // see RULE9 RULE5
      o_com    <= 4'h0;
      o_shared <= 4'h0;
      o_seg    <= '0;
      o_pin_oe <= cfg.discharge;
    end else begin
      o_com    <= com_vec[3:0];
      o_shared <= shared_com ? com_vec[7:4] : seg_vec[3:0];
      o_seg    <= seg_vec[SLD_NSEG-1:4];
      o_pin_oe <= 1'b1;
    end
  end

  // Polarity, monitor, flag and analog controls
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_polarity      <= 1'b0;
      o_wave_b        <= 1'b0;
      o_contrast      <= 5'h00;
      o_internal_gen  <= 1'b0;
      o_frame_monitor <= 1'b0; // see RULE11
      o_frame_irq     <= 1'b0;
      flag            <= 1'b0;
    end else begin
      o_polarity      <= o_polarity ^ tog_pol; // see RULE15
      o_wave_b        <= cfg.wave_b;
      o_contrast      <= cfg.intgen ? cfg.lc : 5'h00; // see RULE20
      o_internal_gen  <= cfg.intgen;
      o_frame_monitor <= o_frame_monitor ^ frame_end; // see RULE24
      // A frame end in the clearing cycle wins
      flag            <= frame_end || (flag && !(wr_intf && i_hwdata[0])); // see RULE21 RULE23
      o_frame_irq     <= flag && cfg.ie; // see RULE23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(a_addr, SLD_OFS_CTRL)) begin
      rd_word[SLD_CTRL_EN]  = cfg.moden;
      rd_word[SLD_CTRL_DIS] = cfg.discharge;
    end else if (hit(a_addr, SLD_OFS_CLK)) begin
      rd_word[SLD_CLK_SRC +: 2] = cfg.src;
      rd_word[SLD_CLK_DIV +: 3] = cfg.div;
      rd_word[SLD_CLK_DEBUG_RUN_ENABLE]    = cfg.debug_run_enable;
    end else if (hit(a_addr, SLD_OFS_TIM1)) begin
      rd_word[SLD_TIM1_DUTY +: 3] = cfg.duty;
      rd_word[SLD_TIM1_FRM +: 4]  = cfg.frm;
    end else if (hit(a_addr, SLD_OFS_TIM2)) begin
      rd_word[SLD_TIM2_WAVEB]      = cfg.wave_b;
      rd_word[SLD_TIM2_NLINE +: 3] = cfg.nline;
    end else if (hit(a_addr, SLD_OFS_PWR)) begin
      rd_word[SLD_PWR_LC +: 5]  = cfg.lc;
      rd_word[SLD_PWR_INTGEN]   = cfg.intgen;
    end else if (hit(a_addr, SLD_OFS_DSP)) begin
      rd_word[SLD_DSP_DISPLAY_STATE_CONTROL +: 2] = cfg.display_state_control;
      rd_word[SLD_DSP_INV]       = cfg.inv;
      rd_word[SLD_DSP_AREA]      = cfg.area;
      rd_word[SLD_DSP_COMREV]    = cfg.comrev;
      rd_word[SLD_DSP_SEGREV]    = cfg.segrev;
      rd_word[SLD_DSP_PART +: 8] = cfg.part;
    end else if (hit(a_addr, SLD_OFS_INTF)) begin
      rd_word[0] = flag;
    end else if (hit(a_addr, SLD_OFS_INTE)) begin
      rd_word[0] = cfg.ie;
    end else if (hit(a_addr, SLD_OFS_STAT)) begin
      rd_word[SLD_STAT_LINE +: 3] = line;
      rd_word[SLD_STAT_MON]       = o_frame_monitor;
      rd_word[SLD_STAT_SUSP]      = susp;
    end else if (ram_hit) begin
      rd_word = {ram[ram_base + 7'd3], ram[ram_base + 7'd2],
                 ram[ram_base + 7'd1], ram[ram_base]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hrdata <= 32'h0000_0000;
      o_hresp  <= 1'b0;
    end else if (rd_pend) begin
      o_hrdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [11:0] frm_ticks;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      frm_ticks <= 12'h000;
    end else if (!cfg.moden || frame_end) begin
      frm_ticks <= 12'h000;
    end else if (op_tick) begin
      frm_ticks <= frm_ticks + 12'h001;
    end
  end

  // A frame cut short by a timing write is not measured
  logic        frm_clean;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      frm_clean <= 1'b1;
    end else if (wr_tim1) begin
      frm_clean <= 1'b0;
    end else if (!cfg.moden || frame_end) begin
      frm_clean <= 1'b1;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  chk_frame_period: assert property (frame_end && frm_clean && $stable(cfg.frm) && $stable(cfg.duty) |->
    32'(frm_ticks) + 1 == 16 * (32'(cfg.frm) + 1) * (32'(cfg.duty) + 1)) // see RULE1
    else $error("frame length differs from divider setting");
  chk_duty_lines: assert property ($stable(cfg.duty) |=> line <= cfg.duty) // see RULE3
    else $error("line index beyond duty");
  chk_suspend_blank: assert property (susp |=> !o_pin_oe || o_com == 4'h0 && o_seg == '0) // see RULE5
    else $error("display not blanked while suspended");
  chk_suspend_hold: assert property (susp && $past(susp) |-> $stable(sub_cnt) && $stable(line)) // see RULE4
    else $error("timing advanced while suspended");
  chk_debug_run: assert property (i_cpu_debug && cfg.debug_run_enable && op_tick |=> sub_cnt != $past(sub_cnt)) // see RULE6
    else $error("timing stopped in debug with run bit set");
  chk_discharge_gnd: assert property (blank && cfg.discharge |=>
    o_pin_oe && o_com == 4'h0 && o_shared == 4'h0 && o_seg == '0) // see RULE9
    else $error("pins not grounded when off with discharge");
  chk_off_float: assert property (blank && !cfg.discharge |=> !o_pin_oe) // see RULE9
    else $error("pins driven when off without discharge");
  chk_flag_clear: assert property (wr_intf && i_hwdata[0] && !frame_end |=> !flag) // see RULE23
    else $error("frame flag not cleared by write of one");
  chk_irq_gate: assert property (##1 o_frame_irq == $past(flag && cfg.ie)) // see RULE23
    else $error("interrupt not gated by enable");
  chk_monitor_toggle: assert property (frame_end |=> o_frame_monitor != $past(o_frame_monitor)) // see RULE24
    else $error("frame monitor did not toggle");

  cov_frame_done: cover property (frame_end && cfg.duty == 3'h7);
  cov_debug_susp: cover property (susp && cfg.moden ##1 !susp);
  cov_flag_race:  cover property (frame_end && wr_intf && i_hwdata[0]);

endmodule : sld_driver
`default_nettype wire

// *** common/sld_pkg.sv ***
// Constants, register map and carrier types of the segment display driver
`default_nettype none
package sld_pkg;

  // Register byte offsets on the bus
  localparam logic [11:0] SLD_OFS_CTRL  = 12'h000;
  localparam logic [11:0] SLD_OFS_CLK   = 12'h004;
  localparam logic [11:0] SLD_OFS_TIM1  = 12'h008;
  localparam logic [11:0] SLD_OFS_TIM2  = 12'h00c;
  localparam logic [11:0] SLD_OFS_PWR   = 12'h010;
  localparam logic [11:0] SLD_OFS_DSP   = 12'h014;
  localparam logic [11:0] SLD_OFS_INTF  = 12'h018;
  localparam logic [11:0] SLD_OFS_INTE  = 12'h01c;
  localparam logic [11:0] SLD_OFS_STAT  = 12'h020;
  localparam logic [3:0]  SLD_RAM_PAGE  = 4'h1;
  localparam logic [5:0]  SLD_RAM_WORDS = 6'h1c;

  // Field positions
  localparam int SLD_CTRL_EN     = 0;
  localparam int SLD_CTRL_DIS    = 1;
  localparam int SLD_CLK_SRC     = 0;
  localparam int SLD_CLK_DIV     = 4;
  localparam int SLD_CLK_DEBUG_RUN_ENABLE   = 8;
  localparam int SLD_TIM1_DUTY   = 0;
  localparam int SLD_TIM1_FRM    = 8;
  localparam int SLD_TIM2_WAVEB  = 0;
  localparam int SLD_TIM2_NLINE  = 4;
  localparam int SLD_PWR_LC      = 0;
  localparam int SLD_PWR_INTGEN  = 8;
  localparam int SLD_DSP_DISPLAY_STATE_CONTROL    = 0;
  localparam int SLD_DSP_INV     = 4;
  localparam int SLD_DSP_AREA    = 5;
  localparam int SLD_DSP_COMREV  = 6;
  localparam int SLD_DSP_SEGREV  = 7;
  localparam int SLD_DSP_PART    = 8;
  localparam int SLD_STAT_LINE   = 0;
  localparam int SLD_STAT_MON    = 4;
  localparam int SLD_STAT_SUSP   = 5;

  // Display state codes
  localparam logic [1:0] SLD_DSP_OFF    = 2'h0;
  localparam logic [1:0] SLD_DSP_NORMAL = 2'h1;
  localparam logic [1:0] SLD_DSP_ALLON  = 2'h2;
  localparam logic [1:0] SLD_DSP_ALLOFF = 2'h3;

  // Geometry and timing
  localparam int         SLD_NCOM      = 8;
  localparam int         SLD_NSEG      = 56;
  localparam int         SLD_ROW_BYTES = 14;
  localparam int         SLD_RAM_BYTES = 112;
  localparam int         SLD_FRAME_DIV = 16;
  localparam logic [2:0] SLD_DUTY_SHARED = 3'h4;
  localparam logic [7:0] SLD_PART_RST  = 8'hff;

  typedef struct packed {
    logic       moden;
    logic       discharge;
    logic [1:0] src;
    logic [2:0] div;
    logic       debug_run_enable;
    logic [2:0] duty;
    logic [3:0] frm;
    logic       wave_b;
    logic [2:0] nline;
    logic [4:0] lc;
    logic       intgen;
    logic [1:0] display_state_control;
    logic       inv;
    logic       area;
    logic       comrev;
    logic       segrev;
    logic [7:0] part;
    logic       ie;
  } sld_cfg_s;

  localparam sld_cfg_s SLD_CFG_RST = '{part: SLD_PART_RST, default: '0};

endpackage : sld_pkg
`default_nettype wire

// *** dv/sld_panel_model.sv ***
// Passive panel model: sees the electrodes and times the frame monitor
`timescale 1ns/100ps
`default_nettype none
module sld_panel_model (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  // Electrodes
  input  wire logic [3:0]  i_com,
  input  wire logic [3:0]  i_shared,
  input  wire logic [51:0] i_seg,
  input  wire logic        i_pin_oe,
  input  wire logic        i_frame_monitor,
  // Observations
  output logic [31:0]      o_toggles,
  output logic [31:0]      o_interval,
  output logic [59:0]      o_level
);
  logic [31:0] cnt;
  logic [31:0] stamp;
  logic        last_mon;

  // Undriven electrodes float: the panel has no pull of its own
  assign o_level = i_pin_oe ? {i_com, i_shared, i_seg} : {60{1'bz}};

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt        <= '0;
      stamp      <= '0;
      last_mon   <= 1'b0;
      o_toggles  <= '0;
      o_interval <= '0;
    end else begin
      cnt      <= cnt + 32'h1;
      last_mon <= i_frame_monitor;
      if (i_frame_monitor != last_mon) begin
        o_toggles  <= o_toggles + 32'h1;
        o_interval <= cnt - stamp;
        stamp      <= cnt;
      end
    end
  end
endmodule : sld_panel_model
`default_nettype wire

// *** dv/sld_driver_bench.sv ***
// Self-checking bench of the segment display driver
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module sld_driver_bench
  import sld_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hresp;
  logic [3:0]  src_tick = 4'h1;
  logic        cpu_dbg = 1'b0;
  logic [3:0]  com;
  logic [3:0]  shared;
  logic [51:0] seg;
  logic        pin_oe;
  logic        polarity;
  logic        wave_b;
  logic [4:0]  contrast;
  logic        intgen;
  logic        mon;
  logic        irq;
  logic [31:0] tog;
  logic [31:0] intv;
  logic [59:0] level;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t;
  int          pol_n = 0;
  logic        pol_d = 1'b0;

  always #5 clk = ~clk;

  sld_driver u_sld_driver (.i_mclk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp),
    .i_src_tick(src_tick), .i_cpu_debug(cpu_dbg), .o_com(com), .o_shared(shared),
    .o_seg(seg), .o_pin_oe(pin_oe), .o_polarity(polarity), .o_wave_b(wave_b),
    .o_contrast(contrast), .o_internal_gen(intgen), .o_frame_monitor(mon),
    .o_frame_irq(irq));

  sld_panel_model u_sld_panel_model (.i_mclk(clk), .i_nrst(nrst), .i_com(com),
    .i_shared(shared), .i_seg(seg), .i_pin_oe(pin_oe), .i_frame_monitor(mon),
    .o_toggles(tog), .o_interval(intv), .o_level(level));

  ////////////////////////////////////////////////////////////////////////////
  // Source 0 ticks every cycle, source 1 every other cycle
  always @(posedge clk) src_tick <= {2'h0, ~src_tick[1], 1'b1};

  // Polarity edges, counted one cycle late like the monitor edges
  always @(posedge clk) begin
    pol_d <= polarity;
    if (polarity !== pol_d) pol_n <= pol_n + 1;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    `CHK(n, e, x)
  endtask : rd_chk

  // Bounded wait for a number of monitor edges
  task automatic wait_tog(input int n);
    logic [31:0] t0;
    t0 = tog;
    repeat (20000) begin
      @(posedge clk);
      if (tog >= t0 + 32'(n)) break;
    end
  endtask : wait_tog

  // Polarity edges over four frames after a fresh start
  task automatic pol_run(input logic [31:0] tim2, input int e);
    int p0;
    wr(SLD_OFS_CTRL, 32'h0);
    wr(SLD_OFS_TIM2, tim2);
    wr(SLD_OFS_CTRL, 32'h1);
    wait_tog(1);
    p0 = pol_n;
    wait_tog(4);
    `CHK("polarity edges", e, pol_n - p0)
  endtask : pol_run

  ////////////////////////////////////////////////////////////////////////////
  int fr[5][4] = '{'{0, 0, 0, 0}, '{1, 2, 0, 0}, '{15, 7, 0, 0}, '{3, 1, 2, 0}, '{0, 0, 0, 1}};
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    `CHK("monitor idle", 1'b0, mon)
    rd_chk("ctrl reset", SLD_OFS_CTRL, 32'h0);
    rd_chk("dsp reset", SLD_OFS_DSP, 32'h0000ff00);
    wr(12'h024, 32'hffffffff);
    rd_chk("unmapped", 12'h024, 32'h0);
    wr(SLD_OFS_TIM1, 32'hffffffff);
    rd_chk("field widths", SLD_OFS_TIM1, 32'h00000f07);
    `CHK("okay", 1'b0, hresp)
    for (int k = 0; k < 28; k++) wr(12'h100 + 12'(4 * k), (k == 27) ? 32'ha5a55a5a : 32'h0);
    rd_chk("ram top", 12'h16c, 32'ha5a55a5a);
    rd_chk("ram past end", 12'h170, 32'h0);
    // Frame period: clear counters before each change so no frame is split
    foreach (fr[i]) begin
      wr(SLD_OFS_CTRL, 32'h0);
      wr(SLD_OFS_CLK, 32'(fr[i][2] << 4) | 32'(fr[i][3]));
      wr(SLD_OFS_TIM1, 32'(fr[i][0] << 8) | 32'(fr[i][1]));
      wr(SLD_OFS_CTRL, 32'h1);
      wait_tog(3);
      `CHK("frame len", 32'(16 * (fr[i][0] + 1) * (fr[i][1] + 1) * (1 << fr[i][2]) * (fr[i][3] + 1)), intv)
    end
    // Debug without run bit, then with it
    wr(SLD_OFS_CLK, 32'h0);
    wr(SLD_OFS_TIM1, 32'h100);
    @(posedge clk) cpu_dbg <= 1'b1;
    repeat (4) @(posedge clk);
    t = tog;
    repeat (100) @(posedge clk);
    `CHK("frozen", 32'(t), tog)
    `CHK("blank", 60'h0, {com, shared, seg})
    rd_chk("kept", SLD_OFS_TIM1, 32'h100);
    @(posedge clk) cpu_dbg <= 1'b0;
    wait_tog(1);
    `CHK("resumed", 1'b1, tog > 32'(t))
    wr(SLD_OFS_CLK, 32'h100);
    @(posedge clk) cpu_dbg <= 1'b1;
    wait_tog(3);
    `CHK("debug run", 32'd32, intv)
    @(posedge clk) cpu_dbg <= 1'b0;
    // Frame interrupt, enable and write-one-clear
    wr(SLD_OFS_INTE, 32'h1);
    wait_tog(1);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    wr(SLD_OFS_INTE, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("irq masked", 1'b0, irq)
    wr(SLD_OFS_CTRL, 32'h0);
    rd_chk("flag set", SLD_OFS_INTF, 32'h1);
    wr(SLD_OFS_INTF, 32'h1);
    rd_chk("flag clear", SLD_OFS_INTF, 32'h0);
    // Pin discharge with display off
    wr(SLD_OFS_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    `CHK("discharge", 60'h0, level)
    wr(SLD_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    `CHK("float", {60{1'bz}}, level)
    // Display codes at quarter duty, then all off at eighth duty
    wr(SLD_OFS_TIM1, 32'h3);
    for (int c = 0; c < 4; c++) begin
      wr(SLD_OFS_DSP, 32'hff00 | 32'(c));
      repeat (40) @(posedge clk);
      `CHK("seg code", (c == 2) ? {52{1'b1}} : 52'h0, seg)
      `CHK("shared as seg", (c == 2) ? 4'hf : 4'h0, shared)
      if (c == 3) `CHK("static com", 4'hf, com)
    end
    wr(SLD_OFS_TIM1, 32'h7);
    repeat (40) @(posedge clk);
    `CHK("shared as com", 4'hf, shared)
    // Waveform type and contrast
    wr(SLD_OFS_TIM2, 32'h1);
    wr(SLD_OFS_PWR, 32'h5);
    repeat (2) @(posedge clk);
    `CHK("wave b", 1'b1, wave_b)
    `CHK("contrast ext", 5'h0, contrast)
    wr(SLD_OFS_PWR, 32'h105);
    repeat (2) @(posedge clk);
    `CHK("contrast int", 5'h5, contrast)
    `CHK("internal gen", 1'b1, intgen)
    // Polarity at half duty; stop first so no line index outlives the duty
    wr(SLD_OFS_CTRL, 32'h0);
    wr(SLD_OFS_CLK, 32'h0);
    wr(SLD_OFS_TIM1, 32'h1);
    pol_run(32'h0, 8);
    pol_run(32'h1, 4);
    pol_run(32'h20, 4);
    // Source 2 never ticks, so line 0 stands still while the display runs
    wr(SLD_OFS_CTRL, 32'h0);
    wr(SLD_OFS_CLK, 32'h2);
    wr(12'h100, 32'h81);
    wr(SLD_OFS_CTRL, 32'h1);
    wr(SLD_OFS_DSP, 32'hffc1);
    repeat (3) @(posedge clk);
    `CHK("com reversed", 4'h2, com)
    `CHK("seg reversed", 52'h8100000000000, seg)
    wr(SLD_OFS_DSP, 32'h0211);
    repeat (3) @(posedge clk);
    `CHK("partial com", 4'h0, com)
    `CHK("inverse shared", 4'he, shared)
    `CHK("inverse seg", 52'hffffffffffff7, seg)
    conclude();
  end
endmodule : sld_driver_bench
`default_nettype wire
